// >>> rtl/osp_pkg.sv
// Package: register map, field layout and timing constants of the serial port
package osp_pkg;
   // Register byte offsets
   localparam logic [11:0] OSP_STATUS_OFF  = 12'h000;
   localparam logic [11:0] OSP_TXHOLD_OFF  = 12'h004;
   localparam logic [11:0] OSP_RXHOLD_OFF  = 12'h008;
   localparam logic [11:0] OSP_CONFIG_OFF  = 12'h00C;
   localparam logic [11:0] OSP_TICKDIV_OFF = 12'h010;
   localparam logic [11:0] OSP_STATE_OFF   = 12'h014;
   // Status word bit positions
   localparam int OSP_TXP_BIT  = 5;
   localparam int OSP_RXEN_BIT = 4;
   localparam int OSP_RDY_BIT  = 3;
   localparam int OSP_OVR_BIT  = 2;
   localparam int OSP_FRM_BIT  = 1;
   localparam int OSP_PAR_BIT  = 0;
   localparam logic [7:0] OSP_STATUS_RST = 8'h00;
   // Config fields: [3:0] data bits N, [7:4] frame length, [8] odd, [9] parity check,
   // [14:10] ticks per bit K
   localparam int OSP_CFG_N_LSB   = 0;
   localparam int OSP_CFG_LEN_LSB = 4;
   localparam int OSP_CFG_ODD_BIT = 8;
   localparam int OSP_CFG_PCK_BIT = 9;
   localparam int OSP_CFG_K_LSB   = 10;
   localparam logic [3:0] OSP_N_RST   = 4'h7;
   localparam logic [3:0] OSP_LEN_RST = 4'hA;
   localparam logic [4:0] OSP_K_RST   = 5'h10;
   localparam logic [15:0] OSP_TICKDIV_RST = 16'h0028;
   localparam logic [15:0] OSP_ZERO16 = 16'h0000;
   localparam logic [4:0]  OSP_ZERO5  = 5'h00;
   localparam logic [3:0]  OSP_ZERO4  = 4'h0;
   localparam logic [4:0]  OSP_ONE5   = 5'h01;
   localparam logic [3:0]  OSP_ONE4   = 4'h1;
   localparam logic [15:0] OSP_ONE16  = 16'h0001;
   typedef enum logic [2:0] {
      OSP_RX_EDGE, OSP_RX_START, OSP_RX_DATA, OSP_RX_PARITY, OSP_RX_STOP
   } osp_rx_state_t;
endpackage

// >>> rtl/osp_serial_port.sv
// Oversampled asynchronous serial port with APB register access
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

module osp_serial_port
   import osp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin,
   output logic             tx_empty_hook,
   output logic             rx_done_hook
);

   //--------------------------------------------------------------
   // State
   //--------------------------------------------------------------
   // All state lives in one record, registered in one place
   typedef struct packed {
      logic [7:0]    stat;
      logic [15:0]   tx_hold;
      logic [15:0]   tx_shf;
      logic [3:0]    tx_left;
      logic          tx_busy;
      logic [4:0]    tx_tick;
      logic [15:0]   rx_hold;
      logic [15:0]   rx_shf;
      logic [3:0]    rx_cnt;
      logic [4:0]    rx_tick;
      logic          rx_par;
      osp_rx_state_t rx_st;
      logic [3:0]    cfg_n;
      logic [3:0]    cfg_len;
      logic          cfg_odd;
      logic          cfg_pck;
      logic [4:0]    cfg_k;
      logic [15:0]   div;
      logic [15:0]   div_cnt;
      logic [31:0]   rdata;
      logic          ready;
      logic          err;
      logic          sout;
      logic          tx_req;
      logic          rx_req;
   } osp_state_t;

   osp_state_t s_q;
   osp_state_t s_d;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   //--------------------------------------------------------------
   // Bus decode and tick helpers
   //--------------------------------------------------------------
   // Receive shift register width, used to right-align a short word
   localparam logic [4:0] RX_SHF_W = 5'h10;

   logic tick;
   logic setup;
   logic acc;
   logic wr;
   logic rd;
   logic mapped;
   logic [4:0] half_k;
   logic [4:0] last_tick;
   logic       last_tx;

   always_comb begin
      setup  = psel && !penable;
      acc    = psel && penable && s_q.ready;
      wr     = acc && pwrite;
      rd     = setup && !pwrite;
      mapped = hit(paddr, OSP_STATUS_OFF) || hit(paddr, OSP_TXHOLD_OFF) ||
               hit(paddr, OSP_RXHOLD_OFF) || hit(paddr, OSP_CONFIG_OFF) ||
               hit(paddr, OSP_TICKDIV_OFF) || hit(paddr, OSP_STATE_OFF);
      tick      = (s_q.div_cnt == OSP_ZERO16);
      // Half a bit rounds down for an odd K
      half_k    = {1'b0, s_q.cfg_k[4:1]};
      last_tick = s_q.cfg_k - OSP_ONE5;
      last_tx   = (s_q.tx_left == OSP_ONE4);
   end

   always_comb begin
      s_d        = s_q;
      s_d.tx_req = 1'b0;
      s_d.rx_req = 1'b0;
      //--------------------------------------------------------------
      // APB slave: no wait state, read data captured at setup
      //--------------------------------------------------------------
      // Writes land only at the access edge at which pready is sampled high
      s_d.ready = setup;
      // Unmapped addresses answer with pslverr and read zero; the error is
      // its own flop so that pslverr comes straight from a register
      s_d.err   = setup && !mapped;
      if (rd) begin
         // Bits above a register's width read zero
         s_d.rdata = 32'h0000_0000;
         if (hit(paddr, OSP_STATUS_OFF)) begin
            s_d.rdata[7:0] = s_q.stat;
         end else if (hit(paddr, OSP_TXHOLD_OFF)) begin
            s_d.rdata[15:0] = s_q.tx_hold;
         end else if (hit(paddr, OSP_RXHOLD_OFF)) begin
            s_d.rdata[15:0] = s_q.rx_hold;
         end else if (hit(paddr, OSP_CONFIG_OFF)) begin
            s_d.rdata[14:0] = {s_q.cfg_k, s_q.cfg_pck, s_q.cfg_odd, s_q.cfg_len, s_q.cfg_n};
         end else if (hit(paddr, OSP_TICKDIV_OFF)) begin
            s_d.rdata[15:0] = s_q.div;
         end else if (hit(paddr, OSP_STATE_OFF)) begin
            s_d.rdata[2:0] = s_q.rx_st;
         end
      end
      if (wr) begin
         if (hit(paddr, OSP_STATUS_OFF)) begin
            // Bits 7 and 6 are never written and read zero
            s_d.stat[5:0] = pwdata[5:0];
         end else if (hit(paddr, OSP_TXHOLD_OFF)) begin
            // Overwrites a word still pending; software checks the flag first
            s_d.tx_hold = pwdata[15:0];
         end else if (hit(paddr, OSP_CONFIG_OFF)) begin
            // New framing acts at once; change it only while both sides idle
            s_d.cfg_n   = pwdata[OSP_CFG_N_LSB +: 4];
            s_d.cfg_len = pwdata[OSP_CFG_LEN_LSB +: 4];
            s_d.cfg_odd = pwdata[OSP_CFG_ODD_BIT];
            s_d.cfg_pck = pwdata[OSP_CFG_PCK_BIT];
            s_d.cfg_k   = pwdata[OSP_CFG_K_LSB +: 5];
         end else if (hit(paddr, OSP_TICKDIV_OFF)) begin
            // A zero divider ticks on every clock
            s_d.div = pwdata[15:0];
         end
      end
      //--------------------------------------------------------------
      // Sampling tick divider
      //--------------------------------------------------------------
      // Tick period is the divider value plus one clock
      s_d.div_cnt = tick ? s_q.div : s_q.div_cnt - OSP_ONE16;
      //--------------------------------------------------------------
      // Transmitter; hardware updates follow the register write so they win
      //--------------------------------------------------------------
      // The pending flag is read in its next value, so a flag set in this cycle
      // is honoured at once; the hardware clear below then wins over the write
      if (tick) begin
         if (!s_q.tx_busy || s_q.tx_tick == last_tick) begin
            s_d.tx_tick = OSP_ZERO5;
            if (s_q.tx_busy && !last_tx) begin
               s_d.tx_shf  = {1'b1, s_q.tx_shf[15:1]};
               s_d.sout    = s_q.tx_shf[1];
               s_d.tx_left = s_q.tx_left - OSP_ONE4;
            end else if (s_d.stat[OSP_TXP_BIT]) begin
               s_d.tx_shf  = s_d.tx_hold;
               s_d.sout    = s_d.tx_hold[0];
               s_d.tx_left = s_q.cfg_len;
               s_d.tx_busy = 1'b1;
               s_d.stat[OSP_TXP_BIT] = 1'b0;
               // Holding word is free again: ask for the next one
               s_d.tx_req  = 1'b1;
            end else begin
               if (s_q.tx_busy) begin
                  s_d.tx_req = 1'b1;
               end
               s_d.tx_busy = 1'b0;
               // Ran dry with nothing pending: back to the mark level
               s_d.sout    = 1'b1;
            end
         end else begin
            s_d.tx_tick = s_q.tx_tick + OSP_ONE5;
         end
      end
      //--------------------------------------------------------------
      // Receiver
      //--------------------------------------------------------------
      // Flags are set after the software status write above, so a hardware
      // event and a clear in the same cycle leave the flag set.
      // State codes 0 to 4 read back through the state register in this order.
      if (tick) begin
         s_d.rx_tick = s_q.rx_tick + OSP_ONE5;
         case (s_q.rx_st)
            OSP_RX_EDGE: begin
               s_d.rx_tick = OSP_ZERO5;
               // With reception disabled the receiver stays here
               if (s_q.stat[OSP_RXEN_BIT] && !serial_in_pin) begin
                  s_d.rx_st = OSP_RX_START;
               end
            end
            OSP_RX_START: begin
               if (s_q.rx_tick + OSP_ONE5 >= half_k) begin
                  s_d.rx_tick = OSP_ZERO5;
                  s_d.rx_shf  = OSP_ZERO16;
                  s_d.rx_cnt  = OSP_ZERO4;
                  s_d.rx_par  = s_q.cfg_odd;
                  // Noise pulse shorter than half a bit goes back to idle
                  s_d.rx_st = serial_in_pin ? OSP_RX_EDGE : OSP_RX_DATA;
               end
            end
            OSP_RX_DATA: begin
               if (s_q.rx_tick == last_tick) begin
                  s_d.rx_tick = OSP_ZERO5;
                  // Samples fall mid-bit, K ticks apart; the LSB arrives first
                  s_d.rx_shf  = {serial_in_pin, s_q.rx_shf[15:1]};
                  s_d.rx_par  = s_q.rx_par ^ serial_in_pin;
                  s_d.rx_cnt  = s_q.rx_cnt + OSP_ONE4;
                  if (s_q.rx_cnt + OSP_ONE4 == s_q.cfg_n) begin
                     s_d.rx_st = OSP_RX_PARITY;
                  end
               end
            end
            OSP_RX_PARITY: begin
               if (s_q.rx_tick == last_tick) begin
                  s_d.rx_tick = OSP_ZERO5;
                  // A one left in the running check after parity is a mismatch
                  s_d.rx_par  = s_q.rx_par ^ serial_in_pin;
                  s_d.rx_st   = OSP_RX_STOP;
               end
            end
            OSP_RX_STOP: begin
               if (s_q.rx_tick == last_tick) begin
                  s_d.rx_tick = OSP_ZERO5;
                  s_d.rx_st   = OSP_RX_EDGE;
                  // Right-align: shift out the unused lower positions
                  s_d.rx_hold = s_q.rx_shf >> (RX_SHF_W - {1'b0, s_q.cfg_n});
                  if (s_q.cfg_pck && s_q.rx_par) begin
                     s_d.stat[OSP_PAR_BIT] = 1'b1;
                  end
                  // Only the first stop bit is looked at
                  if (!serial_in_pin) begin
                     s_d.stat[OSP_FRM_BIT] = 1'b1;
                  end
                  // Overrun looks at ready as it stood before this word
                  if (s_q.stat[OSP_RDY_BIT]) begin
                     s_d.stat[OSP_OVR_BIT] = 1'b1;
                  end
                  s_d.stat[OSP_RDY_BIT] = 1'b1;
                  s_d.rx_req = 1'b1;
               end
            end
            default: begin
               s_d.rx_st = OSP_RX_EDGE;
            end
         endcase
      end
   end

   //--------------------------------------------------------------
   // State register
   //--------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q         <= '0;
         s_q.stat    <= OSP_STATUS_RST;
         s_q.rx_st   <= OSP_RX_EDGE;
         // Wakes up with a usable default framing
         s_q.cfg_n   <= OSP_N_RST;
         s_q.cfg_len <= OSP_LEN_RST;
         s_q.cfg_odd <= 1'b1;
         s_q.cfg_k   <= OSP_K_RST;
         s_q.div     <= OSP_TICKDIV_RST;
         s_q.sout    <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   //--------------------------------------------------------------
   // Outputs, each straight from a flop
   //--------------------------------------------------------------
   assign prdata         = s_q.rdata;
   assign pready         = s_q.ready;
   assign pslverr        = s_q.err;
   assign serial_out_pin = s_q.sout;
   assign tx_empty_hook  = s_q.tx_req;
   assign rx_done_hook   = s_q.rx_req;

endmodule

// >>> verif/osp_line_partner.sv
// Far-side serial equipment: frame sender and frame catcher
`timescale 1ns/1ps
module osp_line_partner #(
   parameter int BP = 8
) (
   input  wire logic pclk,
   input  wire logic serial_out_pin,
   output logic      serial_in_pin
);
   // ------------------------------------------------------------
   // Line model
   // ------------------------------------------------------------
   logic [9:0] rx_frame;
   int         rx_cnt;
   initial serial_in_pin = 1'b1;
   // Sends len bits LSB first, cyc clocks each; line returns to mark
   task automatic send(input logic [9:0] f, input int len, input int cyc);
      for (int i = 0; i < len; i++) begin
         serial_in_pin <= f[i];
         repeat (cyc) @(posedge pclk);
      end
      serial_in_pin <= 1'b1;
   endtask
   // Samples mid-bit after each falling edge, ten bits a frame
   initial begin
      rx_cnt = 0;
      forever begin
         @(negedge serial_out_pin);
         repeat (BP / 2) @(posedge pclk);
         for (int i = 0; i < 10; i++) begin
            rx_frame[i] = serial_out_pin;
            repeat (BP) @(posedge pclk);
         end
         rx_cnt++;
      end
   end
endmodule

// >>> verif/osp_serial_port_asserts.sv
// Port-level checker of the serial port
`timescale 1ns/1ps
module osp_serial_port_asserts
   import osp_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        serial_in_pin,
   input wire logic        serial_out_pin,
   input wire logic        tx_empty_hook,
   input wire logic        rx_done_hook
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_rd(logic [11:0] a);
      pready && !pwrite && paddr == a;
   endsequence
   a_ready_one_wait: assert property (s_setup |=> pready) else $error("pready late");
   a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray pready");
   a_err_unmapped: assert property (pready && !pwrite && paddr > OSP_STATE_OFF
      |-> pslverr && prdata == 0)
      else $error("unmapped not refused");
   a_err_mapped: assert property (pready && paddr <= OSP_STATE_OFF && paddr[1:0] == 2'h0
      |-> !pslverr) else $error("mapped refused");
   a_status_bits: assert property (s_rd(OSP_STATUS_OFF) |-> prdata[31:6] == 26'h0)
      else $error("status high bits set");
   a_state_range: assert property (s_rd(OSP_STATE_OFF) |-> prdata <= 32'h4)
      else $error("state code out of range");
   a_tx_hook_pulse: assert property (tx_empty_hook |=> !tx_empty_hook)
      else $error("tx hook too long");
   a_rx_done_pulse: assert property ($rose(rx_done_hook) |=> $fell(rx_done_hook))
      else $error("rx done too long");
endmodule
bind osp_serial_port osp_serial_port_asserts u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
   .serial_out_pin(serial_out_pin), .tx_empty_hook(tx_empty_hook),
   .rx_done_hook(rx_done_hook));

// >>> verif/test_oversampled_async_serial_port.sv
// Self-checking bench of the serial port
`timescale 1ns/1ps
module test_oversampled_async_serial_port;
   import osp_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, h;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        serial_in_pin, serial_out_pin, tx_empty_hook, rx_done_hook;
   int          n_mismatch, check_count;
   osp_serial_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
      .tx_empty_hook(tx_empty_hook), .rx_done_hook(rx_done_hook));
   // K of 8 ticks, one tick a clock, so a bit lasts 8 clocks
   osp_line_partner #(.BP(8)) peer (.pclk(pclk), .serial_out_pin(serial_out_pin),
      .serial_in_pin(serial_in_pin));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic watch(ref logic s, input int n);
      h = 1'b0;
      repeat (n) begin
         @(posedge pclk);
         if (s === 1'b1) h = 1'b1;
      end
   endtask
   // Start low, data LSB first, odd parity, one high stop; bad flips parity and stop
   function automatic logic [9:0] mkf(logic [6:0] d, logic bad);
      return {~bad, ~(^d) ^ bad, d, 1'b0};
   endfunction
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      apb(1'b0, OSP_STATUS_OFF, 32'h0);
      chk("status reset", rd, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk("unmapped err", {31'h0, er}, 32'h1);
      apb(1'b1, OSP_CONFIG_OFF, 32'h23A7);
      apb(1'b1, OSP_TICKDIV_OFF, 32'h0);
      $display("t_regs done");
   endtask
   task automatic t_tx;
      apb(1'b1, OSP_TXHOLD_OFF, {22'h0, mkf(7'h41, 1'b0)});
      apb(1'b1, OSP_STATUS_OFF, 32'h20);
      watch(tx_empty_hook, 110);
      chk("tx hook", h, 1'b1);
      chk("tx frame", peer.rx_frame, mkf(7'h41, 1'b0));
      apb(1'b0, OSP_STATUS_OFF, 32'h0);
      chk("tx pending", rd, 32'h0);
      watch(tx_empty_hook, 30);
      chk("idle hook", h, 1'b0);
      chk("idle line", serial_out_pin, 1'b1);
      $display("t_tx done");
   endtask
   task automatic t_rx;
      apb(1'b1, OSP_STATUS_OFF, 32'h10);
      fork
         peer.send(mkf(7'h55, 1'b0), 10, 8);
         watch(rx_done_hook, 110);
      join
      chk("rx done", h, 1'b1);
      apb(1'b0, OSP_RXHOLD_OFF, 32'h0);
      chk("rx data", rd, 32'h55);
      apb(1'b0, OSP_STATUS_OFF, 32'h0);
      chk("rx ready", rd, 32'h18);
      fork
         peer.send(mkf(7'h2A, 1'b1), 10, 8);
         watch(rx_done_hook, 110);
      join
      apb(1'b0, OSP_STATUS_OFF, 32'h0);
      chk("rx errors", rd, 32'h1F);
      apb(1'b0, OSP_RXHOLD_OFF, 32'h0);
      chk("rx data2", rd, 32'h2A);
      $display("t_rx done");
   endtask
   task automatic t_rx_off;
      apb(1'b1, OSP_STATUS_OFF, 32'h0);
      fork
         peer.send(mkf(7'h33, 1'b0), 10, 8);
         watch(rx_done_hook, 110);
      join
      chk("rx off", h, 1'b0);
      apb(1'b1, OSP_STATUS_OFF, 32'h10);
      fork
         peer.send(10'h0, 1, 1);
         watch(rx_done_hook, 110);
      join
      chk("noise", h, 1'b0);
      apb(1'b0, OSP_STATE_OFF, 32'h0);
      chk("state idle", rd, 32'h0);
      $display("t_rx_off done");
   endtask
   // Even parity with checking on, then odd parity with checking off
   task automatic t_par;
      apb(1'b1, OSP_CONFIG_OFF, 32'h22A7);
      apb(1'b1, OSP_STATUS_OFF, 32'h10);
      fork
         peer.send(mkf(7'h35, 1'b0), 10, 8);
         watch(rx_done_hook, 110);
      join
      apb(1'b0, OSP_STATUS_OFF, 32'h0);
      chk("even parity", rd, 32'h19);
      apb(1'b1, OSP_CONFIG_OFF, 32'h21A7);
      apb(1'b1, OSP_STATUS_OFF, 32'h10);
      fork
         peer.send(mkf(7'h35, 1'b1), 10, 8);
         watch(rx_done_hook, 110);
      join
      apb(1'b0, OSP_STATUS_OFF, 32'h0);
      chk("parity off", rd, 32'h1A);
      $display("t_par done");
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      n_mismatch = 0;
      check_count = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_tx;
      t_rx;
      t_rx_off;
      t_par;
      stop_test;
   end
   initial begin
      repeat (5000) @(posedge pclk);
      n_mismatch++;
      stop_test;
   end
endmodule
